//--- logic/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] selector_offset = 8'h00;
  localparam logic [7:0] control_offset = 8'h04;
  localparam logic [7:0] trigger_offset = 8'h08;
  localparam logic [7:0] result_offset = 8'h0C;
  localparam logic [7:0] sleep_offset = 8'h10;
  localparam logic [7:0] irq_status_offset = 8'h14;
  localparam logic [7:0] irq_mask_offset = 8'h18;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int enable_pos = 7;
  localparam int go_pos = 6;
  localparam int auto_pos = 5;
  localparam int done_pos = 4;
  localparam int irq_en_pos = 3;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [1:0] channel_reset = 2'h0;
  localparam logic [7:0] result_reset = 8'h00;
  localparam logic [4:0] normal_cycles = 5'h0D;
  localparam logic [4:0] first_cycles = 5'h19;
  localparam logic [4:0] hold_normal_cycles = 5'h03;
  localparam logic [4:0] hold_first_cycles = 5'h10;
  localparam logic [7:0] full_scale = 8'hFF;
  localparam int result_steps = 256;

  // sleep mode encodings
  localparam logic [1:0] sleep_none = 2'h0;
  localparam logic [1:0] sleep_idle = 2'h1;
  localparam logic [1:0] sleep_noise = 2'h2;
  localparam logic [1:0] sleep_other = 2'h3;

  typedef struct packed {
    logic [1:0] channel;
    logic [7:0] sample;
  } analog_type;

endpackage : adc_ctrl_pkg

//--- logic/adc_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module adc_prescaler (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] select,
  // converter clock edge
  output logic tick
);
  import adc_ctrl_pkg::*;

  logic [6:0] count_reg;
  logic [6:0] count_next;
  logic [6:0] limit;

  always_comb begin
    unique case (select)
      3'h0, 3'h1: limit = 7'h01;
      3'h2: limit = 7'h03;
      3'h3: limit = 7'h07;
      3'h4: limit = 7'h0F;
      3'h5: limit = 7'h1F;
      3'h6: limit = 7'h3F;
      3'h7: limit = 7'h7F;
    endcase
  end

  // held in reset while the converter is off, so the phase starts at enable
  always_comb begin
    count_next = count_reg + 7'h01;
    if (!run || restart || count_reg >= limit) begin
      count_next = 7'h00;
    end
  end

  assign tick = run && !restart && (count_reg >= limit);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= 7'h00;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : adc_prescaler
`default_nettype wire

//--- logic/adc_channel_select_control.sv
// Function
// R1: cpu reads and writes the held channel selection at any time.
// R2: while idle the active mux setting follows the held selection.
// R3: once converting, the active setting is frozen against cpu writes.
// R4: copying resumes in the last converter cycle before completion.
// R5: a go request starts conversion on the next converter clock edge.
// R6: software waits one converter cycle after go before changing channel.
// R7: under auto trigger, software changes channel only at safe points.
// R8: a safe channel change applies to the next conversion.
// R9: free running restart keeps the previous channel for that conversion.
// R10: idle or noise sleep with conditions met starts a conversion.
// R11: completion interrupt wakes the cpu from a sleep conversion.
// R12: an earlier wake still gets the completion interrupt request.
// R13: other sleep modes leave the converter enabled.
// R14: result is vin times 256 over reference, 0x00 to 0xFF.
// R15: inputs above reference saturate at full scale.
// R16: result is readable no later than the done flag sets.
// R17: single mode clears go with result store and done flag.
// R18: done flag clears on vector acknowledge or writing one.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_select_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire adc_ctrl_pkg::analog_type analog_in,
  input wire logic trigger_in,
  input wire logic vector_ack,
  output logic [1:0] mux_select,
  output logic sample_hold,
  // interrupt and wake
  output logic irq,
  output logic wake
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    idle_st = 2'b00,
    convert_st = 2'b01
  } conv_state_type;

  conv_state_type state_reg, state_next;
  logic [1:0] held_reg, held_next;
  logic [1:0] active_reg, active_next;
  logic enable_reg, enable_next;
  logic go_reg, go_next;
  logic auto_reg, auto_next;
  logic done_reg, done_next;
  logic irq_en_reg, irq_en_next;
  logic [2:0] prescale_reg, prescale_next;
  logic [2:0] trig_src_reg, trig_src_next;
  logic [1:0] sleep_reg, sleep_next;
  logic [7:0] result_reg, result_next;
  logic [4:0] count_reg, count_next;
  logic first_reg, first_next;
  logic pending_reg, pending_next;
  logic sleep_armed_reg, sleep_armed_next;
  logic sleep_conv_reg, sleep_conv_next;
  logic irq_mask_reg, irq_mask_next;
  logic trig_meta_reg, trig_sync_reg, trig_prev_reg;
  logic [1:0] ch_meta_reg, ch_sync_reg;
  logic [7:0] smp_meta_reg, smp_sync_reg;
  logic [31:0] prdata_reg, prdata_next;

  logic tick;
  logic wr, rd;
  logic trig_edge;
  logic last_cycle;
  logic restart;
  logic [4:0] length;
  logic [4:0] hold_point;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr = psel && penable && pwrite;
  // read data is captured in the setup cycle so it already stands when the access phase is sampled
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // synchronisers for analog side and trigger pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      ch_meta_reg <= 2'h0;
      ch_sync_reg <= 2'h0;
      smp_meta_reg <= 8'h00;
      smp_sync_reg <= 8'h00;
    end else begin
      trig_meta_reg <= trigger_in;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
      ch_meta_reg <= analog_in.channel;
      ch_sync_reg <= ch_meta_reg;
      smp_meta_reg <= analog_in.sample;
      smp_sync_reg <= smp_meta_reg;
    end
  end

  // free running restarts from the completion branch itself, not through a trigger edge
  assign trig_edge = auto_reg && (trig_src_reg != 3'h0) && trig_sync_reg && !trig_prev_reg;
  // edges that arrive while converting are dropped, only an idle converter restarts
  assign restart = trig_edge && (state_reg == idle_st);

  adc_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(enable_reg),
    .restart(restart),
    .select(prescale_reg),
    .tick(tick)
  );

  assign length = first_reg ? first_cycles : normal_cycles;
  // sample instant in converter cycles from the start of conversion
  assign hold_point = first_reg ? hold_first_cycles : hold_normal_cycles;
  assign last_cycle = (state_reg == convert_st) && (count_reg == length - 5'h01);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    held_next = held_reg;
    active_next = active_reg;
    enable_next = enable_reg;
    go_next = go_reg;
    auto_next = auto_reg;
    done_next = done_reg;
    irq_en_next = irq_en_reg;
    prescale_next = prescale_reg;
    trig_src_next = trig_src_reg;
    sleep_next = sleep_reg;
    result_next = result_reg;
    count_next = count_reg;
    first_next = first_reg;
    pending_next = pending_reg;
    sleep_armed_next = sleep_armed_reg;
    sleep_conv_next = sleep_conv_reg;
    irq_mask_next = irq_mask_reg;

    if (wr && hit(paddr, selector_offset)) begin
      held_next = pwdata[1:0]; // R1
    end
    if (wr && hit(paddr, control_offset)) begin
      if (pwdata[enable_pos] && !enable_reg) begin
        first_next = 1'b1;
      end
      enable_next = pwdata[enable_pos];
      auto_next = pwdata[auto_pos];
      irq_en_next = pwdata[irq_en_pos];
      prescale_next = pwdata[2:0];
      // a second go while converting would queue an unwanted extra conversion
      if (pwdata[go_pos] && state_reg == idle_st) begin
        pending_next = 1'b1;
        go_next = 1'b1;
      end
      if (pwdata[done_pos]) begin
        done_next = 1'b0; // R18
      end
    end
    if (wr && hit(paddr, trigger_offset)) begin
      trig_src_next = pwdata[2:0];
    end
    if (wr && hit(paddr, sleep_offset)) begin
      sleep_next = pwdata[1:0];
      sleep_armed_next = 1'b1;
    end
    if (wr && hit(paddr, irq_status_offset) && pwdata[0]) begin
      done_next = 1'b0; // R18
    end
    if (wr && hit(paddr, irq_mask_offset)) begin
      irq_mask_next = pwdata[0];
    end
    if (vector_ack) begin
      done_next = 1'b0; // R18
    end

    // idle or noise sleep starts a conversion once the cpu halts; other modes leave enable alone
    if (sleep_armed_reg) begin // R13
      sleep_armed_next = 1'b0;
      if ((sleep_reg == sleep_idle || sleep_reg == sleep_noise) && enable_reg && state_reg == idle_st
          && !auto_reg && irq_en_reg) begin
        pending_next = 1'b1; // R10
        go_next = 1'b1;
        sleep_conv_next = 1'b1;
      end
    end
    if (restart) begin
      pending_next = 1'b1;
      go_next = 1'b1;
    end

    unique case (state_reg)
      idle_st: begin
        active_next = held_reg; // R2 R8
        if (tick && pending_reg) begin
          state_next = convert_st; // R5
          pending_next = 1'b0;
          count_next = 5'h00;
          active_next = held_reg; // R3
        end
      end
      convert_st: begin
        if (tick) begin
          count_next = count_reg + 5'h01;
        end
        if (last_cycle) begin
          active_next = held_reg; // R4
        end
        if (last_cycle && tick) begin
          // saturated sample code is already clamped by the analog front end
          result_next = (smp_sync_reg > full_scale) ? full_scale : smp_sync_reg; // R14 R15 R16
          // set even if another event already woke the cpu
          done_next = 1'b1; // R11 R12
          first_next = 1'b0;
          sleep_conv_next = 1'b0;
          count_next = 5'h00;
          if (auto_reg && trig_src_reg == 3'h0) begin
            // free running restart keeps the channel just latched
            state_next = convert_st; // R9
          end else begin
            go_next = 1'b0; // R17
            state_next = idle_st;
          end
        end
      end
    endcase

    // disabling aborts any conversion in flight
    if (!enable_next) begin
      state_next = idle_st;
      go_next = 1'b0;
      pending_next = 1'b0;
      count_next = 5'h00;
      sleep_conv_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (rd) begin
      unique case (1'b1)
        hit(paddr, selector_offset): prdata_next = {30'h0000_0000, held_reg}; // R1
        hit(paddr, control_offset): prdata_next = {24'h00_0000, enable_reg, go_reg, auto_reg, done_reg,
                                                   irq_en_reg, prescale_reg};
        hit(paddr, trigger_offset): prdata_next = {29'h0000_0000, trig_src_reg};
        hit(paddr, result_offset): prdata_next = {24'h00_0000, result_reg}; // R16
        hit(paddr, sleep_offset): prdata_next = {30'h0000_0000, sleep_reg};
        hit(paddr, irq_status_offset): prdata_next = {31'h0000_0000, done_reg};
        hit(paddr, irq_mask_offset): prdata_next = {31'h0000_0000, irq_mask_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= idle_st;
      held_reg <= channel_reset;
      active_reg <= channel_reset;
      enable_reg <= control_reset[enable_pos];
      go_reg <= control_reset[go_pos];
      auto_reg <= control_reset[auto_pos];
      done_reg <= control_reset[done_pos];
      irq_en_reg <= control_reset[irq_en_pos];
      prescale_reg <= control_reset[2:0];
      trig_src_reg <= 3'h0;
      sleep_reg <= sleep_none;
      result_reg <= result_reset;
      count_reg <= 5'h00;
      first_reg <= 1'b0;
      pending_reg <= 1'b0;
      sleep_armed_reg <= 1'b0;
      sleep_conv_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      held_reg <= held_next;
      active_reg <= active_next;
      enable_reg <= enable_next;
      go_reg <= go_next;
      auto_reg <= auto_next;
      done_reg <= done_next;
      irq_en_reg <= irq_en_next;
      prescale_reg <= prescale_next;
      trig_src_reg <= trig_src_next;
      sleep_reg <= sleep_next;
      result_reg <= result_next;
      count_reg <= count_next;
      first_reg <= first_next;
      pending_reg <= pending_next;
      sleep_armed_reg <= sleep_armed_next;
      sleep_conv_reg <= sleep_conv_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign mux_select = active_reg; // R3
  assign sample_hold = (state_reg == convert_st) && (count_reg == hold_point);
  assign irq = done_reg && irq_en_reg && irq_mask_reg; // R11 R12
  assign wake = irq;
endmodule : adc_channel_select_control
`default_nettype wire

//--- testbench/adc_select_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module adc_select_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter
  input wire logic vector_ack,
  input wire logic [1:0] mux_select,
  input wire logic sample_hold,
  input wire logic irq,
  input wire logic wake
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // shadow of the held selection
  // ----------------------------------------
  logic [1:0] held_reg;
  logic [1:0] held_next;
  always_comb begin
    held_next = held_reg;
    if (psel && penable && pwrite && paddr == selector_offset) held_next = pwdata[1:0];
  end
  always_ff @(posedge ref_clk) held_reg <= rst ? channel_reset : held_next;
  sequence acc(logic [7:0] a, logic w);
    psel && penable && pwrite == w && paddr == a;
  endsequence
  a_bus_no_error: assert property (pready && !pslverr) else $error("bus answer wrong");
  a_unmapped_zero: assert property (acc(8'h1C, 1'b0) |-> prdata == 32'h0000_0000) else $error("unmapped read");
  a_select_readback: assert property (
    acc(selector_offset, 1'b0) |-> prdata[1:0] == held_reg) else $error("selection readback");
  a_mux_from_held: assert property ($changed(mux_select) |-> mux_select == held_reg)
    else $error("mux not from held");
  a_hold_locks_mux: assert property ($rose(sample_hold) |=> $stable(mux_select)[*8])
    else $error("mux moved in conversion");
  a_wake_irq: assert property (wake == irq) else $error("wake differs from irq");
  a_ack_clears: assert property (vector_ack && irq |=> !irq) else $error("ack kept flag");
  a_flag_w1c: assert property (acc(irq_status_offset, 1'b1) ##0 pwdata[0] |=> !irq)
    else $error("w1c kept flag");
  a_mask_gates: assert property (acc(irq_mask_offset, 1'b1) ##0 !pwdata[0] |=> !irq)
    else $error("masked irq high");
endmodule : adc_select_asserts
bind adc_channel_select_control adc_select_asserts chk_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .vector_ack, .mux_select, .sample_hold, .irq, .wake);
`default_nettype wire

//--- testbench/adc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_analog_model #(
  parameter int vref_mv = 1000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // mux and hold
  input wire logic [1:0] mux_select,
  input wire logic sample_hold,
  output var adc_ctrl_pkg::analog_type analog_out
);
  import adc_ctrl_pkg::*;
  // channel 3 sits above the reference on purpose
  localparam int vin_mv [4] = '{0, 250, 750, 1200};
  function automatic logic [7:0] to_code(input int mv);
    int c;
    c = mv * result_steps / vref_mv;
    return (c > 255) ? full_scale : c[7:0];
  endfunction : to_code
  always_ff @(posedge ref_clk) begin
    if (rst) analog_out <= '0;
    else if (sample_hold) analog_out <= '{mux_select, to_code(vin_mv[mux_select])};
  end
endmodule : adc_analog_model
`default_nettype wire

//--- testbench/adc_channel_select_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_channel_select_control_tb;
  import adc_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic trigger_in = 1'b0;
  logic vector_ack = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] mux_select;
  logic sample_hold;
  logic irq;
  logic wake;
  analog_type analog;
  logic [31:0] rd;
  int fail_count = 0;
  int num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  adc_channel_select_control dut_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .analog_in(analog), .trigger_in, .vector_ack, .mux_select, .sample_hold, .irq, .wake);
  adc_analog_model model_u (.ref_clk, .rst, .mux_select, .sample_hold, .analog_out(analog));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // read data stands through the access phase; take it at the edge that completes it
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rc
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, control_offset, 32'h0000_0000);
      n++;
    end while (rd[done_pos] !== 1'b1 && n < 200);
    if (n >= 200) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_done
  task automatic ack;
    @(posedge ref_clk);
    vector_ack <= 1'b1;
    @(posedge ref_clk);
    vector_ack <= 1'b0;
    @(negedge ref_clk);
  endtask : ack
  task automatic trig;
    @(posedge ref_clk);
    trigger_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    trigger_in <= 1'b0;
  endtask : trig
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rc(control_offset, {24'h00_0000, control_reset});
    rc(result_offset, {24'h00_0000, result_reset});
    rc(selector_offset, 32'h0000_0000);
    wr(8'h1C, 32'h0000_0003);
    rc(8'h1C, 32'h0000_0000);
    wr(irq_mask_offset, 32'h0000_0001);
    wr(selector_offset, 32'h0000_0002);
    rc(selector_offset, 32'h0000_0002);
    chk(32'(mux_select), 32'h0000_0002);
    wr(control_offset, 32'h0000_00C8);
    repeat (2) @(posedge ref_clk);
    wr(selector_offset, 32'h0000_0001);
    repeat (2) @(negedge ref_clk);
    chk(32'(mux_select), 32'h0000_0002);
    wait_done();
    chk(32'(mux_select), 32'h0000_0001);
    rc(result_offset, 32'h0000_00C0);
    rc(control_offset, 32'h0000_0098);
    rc(irq_status_offset, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(irq_status_offset, 32'h0000_0001);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    wr(control_offset, 32'h0000_00C8);
    wait_done();
    rc(result_offset, 32'h0000_0040);
    ack();
    chk(32'(irq), 32'h0000_0000);
    wr(selector_offset, 32'h0000_0003);
    wr(control_offset, 32'h0000_0088);
    for (int m = 1; m < 3; m++) begin
      wr(sleep_offset, 32'(m));
      wait_done();
      chk(32'(wake), 32'h0000_0001);
      rc(result_offset, 32'h0000_00FF);
      ack();
    end
    wr(sleep_offset, {30'h0, sleep_other});
    repeat (60) @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    rc(control_offset, 32'h0000_0088);
    wr(selector_offset, 32'h0000_0001);
    wr(trigger_offset, 32'h0000_0000);
    wr(control_offset, 32'h0000_00E8);
    wait_done();
    rc(result_offset, 32'h0000_0040);
    wr(selector_offset, 32'h0000_0002);
    wr(irq_status_offset, 32'h0000_0001);
    wait_done();
    rc(result_offset, 32'h0000_0040);
    wr(irq_status_offset, 32'h0000_0001);
    wait_done();
    rc(result_offset, 32'h0000_00C0);
    wr(control_offset, 32'h0000_0000);
    wr(irq_status_offset, 32'h0000_0001);
    wr(trigger_offset, 32'h0000_0001);
    wr(control_offset, 32'h0000_00A8);
    trig();
    wait_done();
    rc(result_offset, 32'h0000_00C0);
    wr(selector_offset, 32'h0000_0000);
    wr(irq_status_offset, 32'h0000_0001);
    trig();
    wait_done();
    rc(result_offset, 32'h0000_0000);
    wr(irq_mask_offset, 32'h0000_0000);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    wr(irq_mask_offset, 32'h0000_0001);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0001);
    stop_test();
  end
endmodule : adc_channel_select_control_tb
`default_nettype wire
